// >>> verilog/adsc_ctrl.sv
`timescale 1ns/100ps
`include "adsc_defines.svh"
// How it works
// - run and enable bits encode stopped, standby and running states.
// - hardware wait mode inserts a 1 us settling wait after trigger.
// - run set by software write outside wait mode, or by trigger in wait mode.
// - zero write clears run; single-shot auto-clears except no-wait.
// - reading run returns state, settling counts as running.
// - divider codes 0 to 5 select division by 32 down to 1.
// - speed code 00 is 45 clocks, code 11 is 54 clocks.
// - continuous wait mode settles only after the first trigger.
// - channel mode bit picks single channel or scan.
// - scan width codes give four, three or two channels.
// - repetition bit picks continuous or single-shot.
// - positive reference code picks supply, pin or internal.
// - negative reference bit picks ground or pin.
// - range check decides whether result is stored and flagged.
// - scan results with tagging carry channel in bits 15:12.
// - a conversion-complete request follows every conversion whose result the range check keeps.
module adsc_ctrl
  import adsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Hardware trigger pin.
  input wire logic hw_trigger_i,
  // Analog core.
  input wire logic [11:0] sar_value_i,
  output logic comparator_enable_o,
  output logic sample_o,
  output logic conversion_clock_o,
  output logic [1:0] channel_index_o,
  output logic [1:0] pos_ref_select_o,
  output logic neg_ref_select_o,
  // Conversion complete request.
  output logic conv_done_o
);
  logic conv_run_bit;
  logic comparator_enable_bit;
  logic [2:0] conv_clock_divider;
  logic [7:0] mode_reg;
  logic [7:0] ref_reg;
  logic [7:0] trig_reg;
  logic [11:0] lower_limit_value;
  logic [11:0] upper_limit_value;
  logic [15:0] conversion_result;
  logic [1:0] trg_meta;
  logic trg_prev;
  logic trg_edge;
  adsc_state_t state;
  logic [7:0] settle_cnt;
  logic settled;
  logic [6:0] clk_cnt;
  logic [1:0] chan;
  logic conv_end;
  logic last_chan;
  logic wr;
  logic run_wr1;
  logic run_wr0;
  adsc_trig_t trig_mode;
  logic channel_mode_select;
  logic repetition_select;
  logic [1:0] speed_power_select;
  logic [1:0] scan_last;
  logic [6:0] conv_len;
  logic range_check_select;
  logic channel_tag_enable;
  logic in_range;
  logic keep;
  adsc_clk_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.
  assign trig_mode = adsc_trig_t'(trig_reg[`ADSC_TMD_HI:`ADSC_TMD_LO]);
  assign channel_mode_select = mode_reg[`ADSC_CHM_BIT];
  assign repetition_select = mode_reg[`ADSC_REP_BIT];
  assign speed_power_select = mode_reg[`ADSC_SPD_HI:`ADSC_SPD_LO];
  assign range_check_select = ref_reg[`ADSC_RCK_BIT];
  assign channel_tag_enable = ref_reg[`ADSC_TAG_BIT];
  assign pos_ref_select_o = ref_reg[`ADSC_PREF_HI:`ADSC_PREF_LO];
  assign neg_ref_select_o = ref_reg[`ADSC_NREF_BIT];
  assign comparator_enable_o = comparator_enable_bit;

  // Scan width 00/01/10 ends at index 3/2/1; single mode stays on index 0.
  always_comb begin
    if (!channel_mode_select) begin
      scan_last = 2'h0;
    end else begin
      case (mode_reg[`ADSC_SCW_HI:`ADSC_SCW_LO])
        2'h1: scan_last = 2'h2;
        2'h2: scan_last = 2'h1;
        default: scan_last = 2'h3;
      endcase
    end
  end

  // Prohibited speed codes fall back to the high-speed length.
  assign conv_len = (speed_power_select == 2'h3) ? `ADSC_CONV_LC
                                                 : `ADSC_CONV_HS;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone access; one wait cycle then ack, dropped the cycle after.
  // Writes land on the edge that sees ack high, the same edge at which the
  // master completes the cycle, so a held request never writes twice.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign run_wr1 = wr && (wb_adr_i == `ADSC_OFS_RUN)
                   && wb_dat_i[`ADSC_RUN_BIT];
  assign run_wr0 = wr && (wb_adr_i == `ADSC_OFS_RUN)
                   && !wb_dat_i[`ADSC_RUN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data is registered in the request cycle so it is valid with ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      case (wb_adr_i)
        `ADSC_OFS_RUN: wb_dat_o <= {24'h0, conv_run_bit, 1'b0,
          conv_clock_divider, 2'b00, comparator_enable_bit};
        `ADSC_OFS_MODE: wb_dat_o <= {24'h0, mode_reg};
        `ADSC_OFS_REF: wb_dat_o <= {24'h0, ref_reg};
        `ADSC_OFS_TRIG: wb_dat_o <= {24'h0, trig_reg};
        `ADSC_OFS_LOWER: wb_dat_o <= {20'h0, lower_limit_value};
        `ADSC_OFS_UPPER: wb_dat_o <= {20'h0, upper_limit_value};
        `ADSC_OFS_RESULT: wb_dat_o <= {16'h0, conversion_result};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Configuration registers; reserved bits are held at zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_clock_divider <= 3'h0;
      comparator_enable_bit <= 1'b0;
      mode_reg <= `ADSC_RST_MODE;
      ref_reg <= `ADSC_RST_REF;
      trig_reg <= `ADSC_RST_TRIG;
      lower_limit_value <= 12'h0;
      upper_limit_value <= 12'hfff;
    end else if (wr) begin
      case (wb_adr_i)
        `ADSC_OFS_RUN: begin
          // Software owns and we simply store.
          conv_clock_divider <= wb_dat_i[`ADSC_DIV_HI:`ADSC_DIV_LO];
          comparator_enable_bit <= wb_dat_i[`ADSC_CEN_BIT];
        end
        `ADSC_OFS_MODE: mode_reg <= wb_dat_i[7:0] & 8'heb;
        `ADSC_OFS_REF: ref_reg <= wb_dat_i[7:0] & 8'hea;
        `ADSC_OFS_TRIG: trig_reg <= wb_dat_i[7:0] & 8'hc0;
        `ADSC_OFS_LOWER: lower_limit_value <= wb_dat_i[11:0];
        `ADSC_OFS_UPPER: upper_limit_value <= wb_dat_i[11:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser and rising edge detect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trg_meta <= 2'b00;
      trg_prev <= 1'b0;
    end else begin
      trg_meta <= {trg_meta[0], hw_trigger_i};
      trg_prev <= trg_meta[1];
    end
  end
  // Only the second flop feeds the detector; the first may be metastable.
  assign trg_edge = trg_meta[1] && !trg_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Run bit: write zero always wins; auto-clear after single-shot set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_run_bit <= 1'b0;
    end else if (run_wr0 || !comparator_enable_bit) begin
      conv_run_bit <= 1'b0;
    end else if (trig_mode == ADSC_TRG_HW_WAIT) begin
      if (trg_edge) begin
        conv_run_bit <= 1'b1;
      end else if (conv_end && last_chan && repetition_select) begin
        conv_run_bit <= 1'b0;
      end
    end else if (run_wr1) begin
      conv_run_bit <= 1'b1;
    end else if (conv_end && last_chan && repetition_select
                 && trig_mode != ADSC_TRG_HW_NOWAIT) begin
      conv_run_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Hardware modes wait in HOLD for each trigger that arrives with run already set.
  assign cif.div = conv_clock_divider;
  // Gating with the run bit stops the clock to the core in the cycle after
  // a single-shot end under software trigger, while the state has not yet left conversion.
  assign cif.run = (state == ADSC_ST_CONV) && conv_run_bit;
  assign conv_end = cif.tick && (clk_cnt == conv_len - 7'd1);
  assign last_chan = (chan == scan_last);

  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_run_bit) begin
      state <= ADSC_ST_IDLE;
      settle_cnt <= 8'h0;
      settled <= 1'b0;
    end else begin
      case (state)
        ADSC_ST_IDLE: begin
          if (trig_mode == ADSC_TRG_HW_WAIT && !settled) begin
            state <= ADSC_ST_SETTLE;
          end else if (trig_mode[1]) begin
            state <= ADSC_ST_HOLD;
          end else begin
            state <= ADSC_ST_CONV;
          end
        end
        ADSC_ST_SETTLE: begin
          settle_cnt <= settle_cnt + 8'h1;
          if (settle_cnt == 8'(`ADSC_SETTLE_CYC - 1)) begin
            settled <= 1'b1;
            state <= ADSC_ST_CONV;
          end
        end
        ADSC_ST_CONV: begin
          if (conv_end && last_chan) begin
            state <= (trig_mode[1]) ? ADSC_ST_HOLD : ADSC_ST_CONV;
          end
        end
        ADSC_ST_HOLD: begin
          if (trg_edge) begin
            state <= ADSC_ST_CONV;
          end
        end
        default: state <= ADSC_ST_IDLE;
      endcase
    end
  end

  // Conversion clock count and channel index.
  always_ff @(posedge clk_i) begin
    if (rst_i || state != ADSC_ST_CONV) begin
      clk_cnt <= 7'h0;
      chan <= 2'h0;
    end else if (cif.tick) begin
      if (conv_end) begin
        clk_cnt <= 7'h0;
        chan <= last_chan ? 2'h0 : chan + 2'h1;
      end else begin
        clk_cnt <= clk_cnt + 7'h1;
      end
    end
  end

  // Sampling covers the first 13.5 clocks; 14 whole clocks here.
  assign sample_o = cif.run && (clk_cnt < 7'd14);
  assign conversion_clock_o = cif.tick;
  assign channel_index_o = chan;

  ////////////////////////////////////////////////////////////////////////////
  // Range check gates result storage and the done pulse.
  assign in_range = (sar_value_i >= lower_limit_value)
                    && (sar_value_i <= upper_limit_value);
  assign keep = in_range ^ range_check_select;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_result <= 16'h0;
      conv_done_o <= 1'b0;
    end else begin
      conv_done_o <= conv_end && keep;
      if (conv_end && keep) begin
        conversion_result <= {(channel_mode_select && channel_tag_enable)
          ? {2'b00, chan} : 4'h0, sar_value_i};
      end
    end
  end

  adsc_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cif(cif.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_run_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_run_bit |-> comparator_enable_bit)
    else $error("run set with enable clear");
  // The settling counter must have run its full length when settling ends.
  chk_settle_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(state == ADSC_ST_SETTLE) && conv_run_bit |->
    $past(settle_cnt) == 8'(`ADSC_SETTLE_CYC - 1))
    else $error("settle length wrong");
  chk_zero_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    run_wr0 |=> !conv_run_bit)
    else $error("run not cleared");
  chk_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.run && conv_clock_divider == 3'h5 |-> cif.tick)
    else $error("divide by one broken");
  chk_done_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done_o |-> $past(keep))
    else $error("done without range pass");
  chk_done_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end && keep |=> conv_done_o)
    else $error("missing done");
  chk_single_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    !channel_mode_select |-> chan == 2'h0)
    else $error("single mode stepped channel");
  chk_wait_set: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_mode == ADSC_TRG_HW_WAIT && trg_edge && comparator_enable_bit
    && !run_wr0 |=> conv_run_bit)
    else $error("trigger did not set run");
  cov_scan: cover property (@(posedge clk_i) conv_end && chan == 2'h3);
  cov_settle: cover property (@(posedge clk_i) state == ADSC_ST_SETTLE);
  cov_auto: cover property (@(posedge clk_i) $fell(conv_run_bit) && !run_wr0);
endmodule

// >>> verilog/adsc_defines.svh
`ifndef ADSC_DEFINES_SVH
`define ADSC_DEFINES_SVH
// Register byte addresses on the bus.
`define ADSC_OFS_RUN 8'h00
`define ADSC_OFS_MODE 8'h04
`define ADSC_OFS_REF 8'h08
`define ADSC_OFS_TRIG 8'h0c
`define ADSC_OFS_LOWER 8'h10
`define ADSC_OFS_UPPER 8'h14
`define ADSC_OFS_RESULT 8'h18
// Run register fields.
`define ADSC_RUN_BIT 7
`define ADSC_DIV_HI 5
`define ADSC_DIV_LO 3
`define ADSC_CEN_BIT 0
// Mode register fields.
`define ADSC_CHM_BIT 7
`define ADSC_SCW_HI 6
`define ADSC_SCW_LO 5
`define ADSC_REP_BIT 3
`define ADSC_SPD_HI 1
`define ADSC_SPD_LO 0
// Reference register fields.
`define ADSC_PREF_HI 7
`define ADSC_PREF_LO 6
`define ADSC_NREF_BIT 5
`define ADSC_RCK_BIT 3
`define ADSC_TAG_BIT 1
// Trigger register fields.
`define ADSC_TMD_HI 7
`define ADSC_TMD_LO 6
// Reset values.
`define ADSC_RST_RUN 8'h00
`define ADSC_RST_MODE 8'h00
`define ADSC_RST_REF 8'h00
`define ADSC_RST_TRIG 8'h00
// Timing.
`define ADSC_CLK_MHZ 200
`define ADSC_SETTLE_NS 1000
`define ADSC_SETTLE_CYC ((`ADSC_SETTLE_NS * `ADSC_CLK_MHZ + 999) / 1000)
`define ADSC_CONV_HS 7'd45
`define ADSC_CONV_LC 7'd54
`endif

// >>> verilog/adsc_pkg.sv
package adsc_pkg;
  typedef enum logic [1:0] {
    ADSC_TRG_SW,
    ADSC_TRG_SW2,
    ADSC_TRG_HW_NOWAIT,
    ADSC_TRG_HW_WAIT
  } adsc_trig_t;
  typedef enum logic [1:0] {
    ADSC_ST_IDLE,
    ADSC_ST_SETTLE,
    ADSC_ST_CONV,
    ADSC_ST_HOLD
  } adsc_state_t;
endpackage

// >>> verilog/adsc_clk_if.sv
`timescale 1ns/100ps
interface adsc_clk_if;
  logic [2:0] div;
  logic run;
  logic tick;
  modport ctl (output div, output run, input tick);
  modport gen (input div, input run, output tick);
endinterface

// >>> verilog/adsc_clkdiv.sv
`timescale 1ns/100ps
`include "adsc_defines.svh"
module adsc_clkdiv
  import adsc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Divider control.
  adsc_clk_if.gen cif
);
  logic [4:0] cnt;
  logic [4:0] limit;

  // Codes 0..5 give /32 down to /1.
  always_comb begin
    case (cif.div)
      3'h0: limit = 5'h1f;
      3'h1: limit = 5'h0f;
      3'h2: limit = 5'h07;
      3'h3: limit = 5'h03;
      3'h4: limit = 5'h01;
      default: limit = 5'h00;
    endcase
  end

  // Counter restarts whenever the converter is idle so ticks align to start.
  always_ff @(posedge clk_i) begin
    if (rst_i || !cif.run || cnt >= limit) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

  assign cif.tick = cif.run && (cnt >= limit);
endmodule

// >>> tb/adsc_core_model.sv
`timescale 1ns/100ps
module adsc_core_model (
  // Clock.
  input wire logic clk_i,
  // Bench control.
  input wire logic fire_i,
  input wire logic [11:0] value_i,
  // Converter side.
  input wire logic comparator_enable_i,
  input wire logic sample_i,
  output logic [11:0] sar_value_o,
  output logic hw_trigger_o
);
  logic [11:0] junk = 12'h000;
  int hold = 0;

  //////////////////////////////////////////////////////////////////////////
  // An unpowered or sampling comparator shows a pattern that changes every
  // cycle, so a result taken at the wrong moment cannot pass by luck.
  always @(posedge clk_i) begin
    junk <= ~junk ^ 12'h5a5;
  end
  assign sar_value_o = (comparator_enable_i && !sample_i) ? value_i : junk;

  //////////////////////////////////////////////////////////////////////////
  // Trigger source: a short high level per request; callers space requests.
  always @(posedge clk_i) begin
    if (fire_i) begin
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  assign hw_trigger_o = (hold > 0);
endmodule

// >>> tb/adc_sequencing_control_tb.sv
`timescale 1ns/100ps
module adc_sequencing_control_tb;
  import adsc_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_we, wb_ack, fire, trig, cen, smp, cclk;
  logic done, nref;
  logic [7:0] wb_adr;
  logic [3:0] lane;
  logic [31:0] wb_dat, wb_rdat;
  logic [11:0] sar, sar_val;
  logic [1:0] chan, pref;
  logic [31:0] rd_q[$];
  logic [31:0] cv_q[$];
  int num_errors = 0;
  int compares = 0;
  int cnt = 0;
  int since = 0;
  int gap = 0;
  int n;
  logic [1:0] ch_seen = 2'h0;

  adsc_ctrl u_adsc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(lane),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .hw_trigger_i(trig), .sar_value_i(sar), .comparator_enable_o(cen),
    .sample_o(smp), .conversion_clock_o(cclk), .channel_index_o(chan),
    .pos_ref_select_o(pref), .neg_ref_select_o(nref), .conv_done_o(done));

  adsc_core_model u_adsc_core_model (.clk_i(clk_i), .fire_i(fire),
    .value_i(sar_val), .comparator_enable_i(cen), .sample_i(smp),
    .sar_value_o(sar), .hw_trigger_o(trig));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // A bus access; reads note their expected data before the request rises.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    if (!w) rd_q.push_back(d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= w ? d : 32'h0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    wb_cyc <= 1'b0;
    if (wb_ack !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic wait_done(input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (done !== 1'b1 && k < lim);
    if (k >= lim) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  // Stop, configure, enter standby and let the comparator settle.
  task automatic setup(input logic [7:0] m, t, input logic [2:0] dv);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, {24'h0, m});
    wb(1'b1, 8'h0c, {24'h0, t});
    wb(1'b1, 8'h00, {26'h0, dv, 3'h1});
    repeat (200) @(posedge clk_i);
  endtask

  task automatic go(input logic [2:0] dv);
    wb(1'b1, 8'h00, {24'h0, 2'b10, dv, 3'h1});
  endtask

  task automatic pulse_trigger;
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Read data is compared against the oldest note at the ack edge.
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0)
      chk("read data", rd_q.pop_front(), wb_rdat);
  end

  // Conversion clocks are counted per result and the last spacing kept.
  // The done check runs first: at a divide-by-one the tick seen with done
  // already belongs to the next conversion.
  always @(posedge clk_i) begin
    logic [31:0] e;
    since++;
    if (done === 1'b1) begin
      if (cv_q.size() == 0) begin
        chk("unexpected done", 32'h0, 32'h1);
      end else begin
        e = cv_q.pop_front();
        chk("clock count", {16'h0, e[15:0]}, cnt);
        chk("clock gap", {18'h0, e[29:16]}, gap);
        chk("channel", {30'h0, e[31:30]}, {30'h0, ch_seen});
      end
      cnt = 0;
    end
    if (cclk === 1'b1) begin
      cnt++;
      gap = since;
      since = 0;
      ch_seen = chan;
    end
    if (wb_ack === 1'b1 && wb_we === 1'b1) cnt = 0;
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] spd;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h0;
    wb_dat = 32'h0;
    lane = 4'hf;
    fire = 1'b0;
    sar_val = 12'h0;
    void'($urandom(24));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, an unmapped place and a write without lane 0.
    wb(1'b0, 8'h00, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    wb(1'b0, 8'h1c, 32'h0);
    lane <= 4'he;
    wb(1'b1, 8'h08, 32'hff);
    lane <= 4'hf;
    wb(1'b0, 8'h08, 32'h0);
    // Divider codes 0 to 5, both speed modes, single-shot single channel.
    for (int dv = 0; dv < 6; dv++) begin
      spd = dv[0] ? 2'b11 : 2'b00;
      sar_val <= 12'($urandom);
      cv_q.push_back({16'(32 >> dv), spd[0] ? 16'd54 : 16'd45});
      setup({6'h02, spd}, dv[1] ? 8'h40 : 8'h00, 3'(dv));
      go(3'(dv));
      wait_done(2000, n);
      repeat (4) @(posedge clk_i);
      wb(1'b0, 8'h18, {20'h0, sar_val});
      wb(1'b0, 8'h00, {26'h0, 3'(dv), 3'h1});
    end
    // Three-channel single-shot scan stops by itself after the set.
    for (int i = 0; i < 3; i++) cv_q.push_back({2'(i), 14'd1, 16'd45});
    wb(1'b1, 8'h08, 32'h02);
    setup(8'ha8, 8'h00, 3'h5);
    go(3'h5);
    for (int i = 0; i < 3; i++) wait_done(200, n);
    repeat (100) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h29);
    wb(1'b0, 8'h18, {16'h0, 4'h2, sar_val});
    // Range check: inside-only drops an outside result, outside keeps it.
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h10, 32'h100);
    wb(1'b1, 8'h14, 32'h200);
    sar_val <= 12'h050;
    setup(8'h08, 8'h00, 3'h5);
    go(3'h5);
    repeat (300) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h08);
    cv_q.push_back({16'd1, 16'd45});
    setup(8'h08, 8'h00, 3'h5);
    go(3'h5);
    wait_done(200, n);
    // No-wait trigger, single-shot: run stays set after the result.
    cv_q.push_back({16'd1, 16'd45});
    setup(8'h08, 8'h80, 3'h5);
    go(3'h5);
    pulse_trigger();
    wait_done(200, n);
    wb(1'b0, 8'h00, 32'ha9);
    // Wait trigger, continuous: settle only before the first conversion.
    cv_q.push_back({16'd1, 16'd45});
    cv_q.push_back({16'd1, 16'd45});
    setup(8'h00, 8'hc0, 3'h5);
    pulse_trigger();
    wait_done(400, n);
    chk("first latency", 32'h1, 32'(n >= 245 && n <= 255));
    wb(1'b0, 8'h00, 32'ha9);
    repeat (10) @(posedge clk_i);
    pulse_trigger();
    wait_done(400, n);
    chk("next latency", 32'h1, 32'(n >= 45 && n <= 55));
    wb(1'b1, 8'h00, 32'h29);
    wb(1'b0, 8'h00, 32'h29);
    // Reference selects follow their register fields.
    wb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 8'h08, {24'h0, 2'(i % 3), 1'(i / 3), 5'h0});
      @(negedge clk_i);
      chk("pos ref", 32'(i % 3), {30'h0, pref});
      chk("neg ref", 32'(i / 3), {31'h0, nref});
    end
    report_and_stop();
  end
endmodule
